// *** include/ptd_pkg.sv ***
// Package: constants, carriers and states of the program table and data map block
package ptd_pkg;

    // ==================================================================
    // Widths
    localparam int PTD_PM_AW = 11;
    localparam int PTD_DM_AW = 8;

    // ==================================================================
    // Program memory
    localparam logic [10:0] PTD_PC_RESET_VEC = 11'h000;
    localparam logic [2:0]  PTD_LAST_PAGE    = 3'h7;

    // ==================================================================
    // Data memory map
    localparam logic [7:0] PTD_SFR_TOP   = 8'h7F;
    localparam logic [7:0] PTD_EEC_ADDR  = 8'h40;
    localparam logic [7:0] PTD_GP_BASE   = 8'h80;
    localparam logic [7:0] PTD_GP_LAST   = 8'hBF;
    localparam logic [7:0] PTD_BSP_ADDR  = 8'h04;
    localparam logic [7:0] PTD_TBLP_ADDR = 8'h07;
    localparam logic [7:0] PTD_TBHP_ADDR = 8'h08;
    localparam logic [7:0] PTD_TABLE_HIGH_LATCH_ADDR = 8'h09;
    localparam logic [7:0] PTD_UNIMPL    = 8'h00;
    localparam int         PTD_BANK_BIT  = 0;

    // ==================================================================
    // Reset values
    localparam logic [7:0] PTD_BSP_RST  = 8'h00;
    localparam logic [7:0] PTD_TBLP_RST = 8'h00;
    localparam logic [7:0] PTD_TBHP_RST = 8'h00;
    localparam logic [7:0] PTD_TABLE_HIGH_LATCH_RST = 8'h00;

    // ==================================================================
    // Serial programming link
    localparam logic [2:0] PTD_ICP_LAST_BIT = 3'h7;

    // ==================================================================
    // Carriers and states
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       indirect;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ptd_dm_req_t;

    typedef struct packed {
        logic       valid;
        logic       last_page;
        logic [7:0] dest;
    } ptd_tbl_req_t;

    typedef enum logic [1:0] {
        TBL_IDLE    = 2'b00,
        TBL_FETCH   = 2'b01,
        TBL_CAPTURE = 2'b10
    } ptd_tbl_state_t;

    typedef enum logic [2:0] {
        RG_NONE  = 3'b000,
        RG_BSP   = 3'b001,
        RG_TBLP  = 3'b010,
        RG_TBHP  = 3'b011,
        RG_TABLE_HIGH_LATCH  = 3'b100,
        RG_EXT   = 3'b101,
        RG_EEC   = 3'b110,
        RG_GPRAM = 3'b111
    } ptd_region_t;

endpackage : ptd_pkg

// *** src/ptd_gpram.sv ***
// General purpose data RAM, one byte wide, synchronous read
module ptd_gpram
#(
    parameter int DEPTH = 64,
    parameter int AW    = 6
)
(
    // Clock
    input  wire logic          clk_sys,
    // Access
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata_q
);
    import ptd_pkg::*;

    // ==================================================================
    // Storage: contents are volatile, no reset
    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_d;

    always_comb
    begin
        rdata_d = mem[raddr];
    end

    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_q <= rdata_d;
    end

endmodule : ptd_gpram

// *** src/ptd_core.sv ***
// Program table read path, reset vector, banked data map and serial programming pins
// ==================================================================
module ptd_core
#(
    parameter int PM_WORD_W = 16,
    parameter int GP_DEPTH  = 64
)
(
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Program counter control
    input  wire logic                       pc_step,
    input  wire logic                       pc_load,
    input  wire logic [ptd_pkg::PTD_PM_AW-1:0] pc_load_addr,
    output logic      [ptd_pkg::PTD_PM_AW-1:0] pc_q,
    // Table read request
    input  wire ptd_pkg::ptd_tbl_req_t      tbl_req,
    output logic                            tbl_busy_q,
    output logic                            tbl_done_q,
    // Program memory read port
    output logic      [ptd_pkg::PTD_PM_AW-1:0] pm_addr_q,
    output logic                            pm_rd_q,
    input  wire logic [PM_WORD_W-1:0]       pm_data,
    // Data memory access
    input  wire ptd_pkg::ptd_dm_req_t       dm_req,
    output logic      [7:0]                 dm_rdata_q,
    output logic                            dm_rvalid_q,
    output logic      [7:0]                 bank_select_pointer_q,
    // Other special function registers
    output logic      [7:0]                 sfr_addr_q,
    output logic      [7:0]                 sfr_wdata_q,
    output logic                            sfr_rd_q,
    output logic                            sfr_wr_q,
    output logic                            eeprom_sel_q,
    input  wire logic [7:0]                 sfr_rdata,
    input  wire logic                       sfr_hit,
    // Serial programming pins
    input  wire logic                       prog_serial_clock,
    input  wire logic                       prog_serial_data_i,
    output logic                            prog_serial_data_o_q,
    output logic                            prog_serial_data_oe_q,
    output logic      [7:0]                 icp_rx_byte_q,
    output logic                            icp_rx_valid_q,
    input  wire logic                       icp_tx_load,
    input  wire logic [7:0]                 icp_tx_byte
);
    import ptd_pkg::*;

    localparam int GP_AW = $clog2(GP_DEPTH);

    // ==================================================================
    // Address decode, shared by software and table write paths
    function automatic ptd_region_t dm_decode(input logic [7:0] a, input logic bank1);
        ptd_region_t r;
        r = RG_NONE;
        if (a <= PTD_SFR_TOP)
        begin
            if (a == PTD_EEC_ADDR)
                r = bank1 ? RG_EEC : RG_NONE;
            else if (a == PTD_BSP_ADDR)
                r = RG_BSP;
            else if (a == PTD_TBLP_ADDR)
                r = RG_TBLP;
            else if (a == PTD_TBHP_ADDR)
                r = RG_TBHP;
            else if (a == PTD_TABLE_HIGH_LATCH_ADDR)
                r = RG_TABLE_HIGH_LATCH;
            else
                r = RG_EXT;
        end
        else if (!bank1 && a <= PTD_GP_LAST)
        begin
            r = RG_GPRAM;
        end
        return r;
    endfunction : dm_decode

    // ==================================================================
    // Program counter
    logic [PTD_PM_AW-1:0] pc_d;

    always_comb
    begin
        pc_d = pc_q;
        if (pc_load)
            pc_d = pc_load_addr;
        else if (pc_step)
            pc_d = pc_q + 11'h001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pc_q <= PTD_PC_RESET_VEC;
        else
            pc_q <= pc_d;
    end

    // ==================================================================
    // Table read sequencer
    ptd_tbl_state_t       tbl_st_q, tbl_st_d;
    logic [7:0]           tbl_dest_q, tbl_dest_d;
    logic [PTD_PM_AW-1:0] pm_addr_d;
    logic                 pm_rd_d, tbl_busy_d, tbl_done_d;
    logic [7:0]           tblp_q, tblp_d, tbhp_q, tbhp_d, table_high_latch_q, table_high_latch_d;
    logic [7:0]           bsp_d;
    logic [15:0]          pm_word_ext;
    logic                 tbl_wr;

    // Zero padding of a narrow word makes missing high bits read as zero
    assign pm_word_ext = 16'(pm_data);
    assign tbl_wr      = (tbl_st_q == TBL_CAPTURE);

    always_comb
    begin
        tbl_st_d   = tbl_st_q;
        tbl_dest_d = tbl_dest_q;
        pm_addr_d  = pm_addr_q;
        pm_rd_d    = 1'b0;
        tbl_done_d = 1'b0;
        unique case (tbl_st_q)
            TBL_IDLE:
            begin
                if (tbl_req.valid)
                begin
                    tbl_st_d   = TBL_FETCH;
                    tbl_dest_d = tbl_req.dest;
                    pm_rd_d    = 1'b1;
                    if (tbl_req.last_page)
                        pm_addr_d = {PTD_LAST_PAGE, tblp_q};
                    else
                        pm_addr_d = {tbhp_q[2:0], tblp_q};
                end
            end
            TBL_FETCH:
            begin
                tbl_st_d = TBL_CAPTURE;
            end
            TBL_CAPTURE:
            begin
                tbl_st_d   = TBL_IDLE;
                tbl_done_d = 1'b1;
            end
            default:
            begin
                tbl_st_d = TBL_IDLE;
            end
        endcase
        tbl_busy_d = (tbl_st_d != TBL_IDLE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tbl_st_q   <= TBL_IDLE;
            tbl_dest_q <= 8'h00;
            pm_addr_q  <= PTD_PC_RESET_VEC;
            pm_rd_q    <= 1'b0;
            tbl_busy_q <= 1'b0;
            tbl_done_q <= 1'b0;
        end
        else
        begin
            tbl_st_q   <= tbl_st_d;
            tbl_dest_q <= tbl_dest_d;
            pm_addr_q  <= pm_addr_d;
            pm_rd_q    <= pm_rd_d;
            tbl_busy_q <= tbl_busy_d;
            tbl_done_q <= tbl_done_d;
        end
    end

    // ==================================================================
    // Data memory access; requests are ignored while a table read runs
    logic        acc_take, acc_bank1, wr_en, gp_we;
    logic [7:0]  wr_addr, wr_data;
    ptd_region_t acc_rg, wr_rg;
    ptd_region_t rd_rg_q, rd_rg_d;
    logic        rd_pend_q, rd_pend_d;
    logic [7:0]  rd_fix_q, rd_fix_d;
    logic [7:0]  dm_rdata_d, gp_rdata_q;
    logic        dm_rvalid_d;
    logic [7:0]  sfr_addr_d, sfr_wdata_d;
    logic        sfr_rd_d, sfr_wr_d, eec_d;

    assign acc_take  = (dm_req.rd || dm_req.wr) && (tbl_st_q == TBL_IDLE);
    // Only indirect accesses follow the bank pointer
    assign acc_bank1 = dm_req.indirect && bank_select_pointer_q[PTD_BANK_BIT];
    assign acc_rg    = dm_decode(dm_req.addr, acc_bank1);
    // Table operand is a direct address, hence bank 0
    assign wr_addr   = tbl_wr ? tbl_dest_q : dm_req.addr;
    assign wr_data   = tbl_wr ? pm_word_ext[7:0] : dm_req.wdata;
    assign wr_rg     = tbl_wr ? dm_decode(tbl_dest_q, 1'b0) : acc_rg;
    assign wr_en     = tbl_wr || (acc_take && dm_req.wr);
    assign gp_we     = wr_en && (wr_rg == RG_GPRAM);

    always_comb
    begin
        bsp_d  = bank_select_pointer_q;
        tblp_d = tblp_q;
        tbhp_d = tbhp_q;
        table_high_latch_d = table_high_latch_q;
        if (wr_en && wr_rg == RG_BSP)
            bsp_d = {7'h00, wr_data[PTD_BANK_BIT]};
        if (wr_en && wr_rg == RG_TBLP)
            tblp_d = wr_data;
        if (wr_en && wr_rg == RG_TBHP)
            tbhp_d = {5'h00, wr_data[2:0]};
        // Software writes to the latch fall through here with no effect
        if (tbl_wr)
            table_high_latch_d = pm_word_ext[15:8];
    end

    always_comb
    begin
        rd_pend_d   = acc_take && dm_req.rd;
        rd_rg_d     = acc_rg;
        rd_fix_d    = PTD_UNIMPL;
        sfr_addr_d  = dm_req.addr;
        sfr_wdata_d = dm_req.wdata;
        sfr_rd_d    = acc_take && dm_req.rd && (acc_rg == RG_EXT || acc_rg == RG_EEC);
        sfr_wr_d    = acc_take && dm_req.wr && (acc_rg == RG_EXT || acc_rg == RG_EEC);
        eec_d       = acc_take && (acc_rg == RG_EEC);
        unique case (acc_rg)
            RG_BSP:   rd_fix_d = bank_select_pointer_q;
            RG_TBLP:  rd_fix_d = tblp_q;
            RG_TBHP:  rd_fix_d = tbhp_q;
            RG_TABLE_HIGH_LATCH:  rd_fix_d = table_high_latch_q;
            RG_NONE, RG_EXT, RG_EEC, RG_GPRAM: rd_fix_d = PTD_UNIMPL;
        endcase
        dm_rvalid_d = rd_pend_q;
        dm_rdata_d  = PTD_UNIMPL;
        if (rd_pend_q)
        begin
            unique case (rd_rg_q)
                RG_GPRAM:       dm_rdata_d = gp_rdata_q;
                RG_EXT, RG_EEC: dm_rdata_d = sfr_hit ? sfr_rdata : PTD_UNIMPL;
                RG_NONE, RG_BSP, RG_TBLP, RG_TBHP, RG_TABLE_HIGH_LATCH: dm_rdata_d = rd_fix_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            bank_select_pointer_q <= PTD_BSP_RST;
            tblp_q       <= PTD_TBLP_RST;
            tbhp_q       <= PTD_TBHP_RST;
            table_high_latch_q       <= PTD_TABLE_HIGH_LATCH_RST;
            rd_pend_q    <= 1'b0;
            rd_rg_q      <= RG_NONE;
            rd_fix_q     <= PTD_UNIMPL;
            dm_rdata_q   <= PTD_UNIMPL;
            dm_rvalid_q  <= 1'b0;
            sfr_addr_q   <= 8'h00;
            sfr_wdata_q  <= 8'h00;
            sfr_rd_q     <= 1'b0;
            sfr_wr_q     <= 1'b0;
            eeprom_sel_q <= 1'b0;
        end
        else
        begin
            bank_select_pointer_q <= bsp_d;
            tblp_q       <= tblp_d;
            tbhp_q       <= tbhp_d;
            table_high_latch_q       <= table_high_latch_d;
            rd_pend_q    <= rd_pend_d;
            rd_rg_q      <= rd_rg_d;
            rd_fix_q     <= rd_fix_d;
            dm_rdata_q   <= dm_rdata_d;
            dm_rvalid_q  <= dm_rvalid_d;
            sfr_addr_q   <= sfr_addr_d;
            sfr_wdata_q  <= sfr_wdata_d;
            sfr_rd_q     <= sfr_rd_d;
            sfr_wr_q     <= sfr_wr_d;
            eeprom_sel_q <= eec_d;
        end
    end

    ptd_gpram #(.DEPTH(GP_DEPTH), .AW(GP_AW)) u_gpram
    (
        .clk_sys (clk_sys),
        .we      (gp_we),
        .waddr   (wr_addr[GP_AW-1:0]),
        .wdata   (wr_data),
        .raddr   (dm_req.addr[GP_AW-1:0]),
        .rdata_q (gp_rdata_q)
    );

    // ==================================================================
    // Serial programming pins: three-flop synchronisers
    logic [1:0] pin_raw;
    logic [1:0] sync1_q, sync2_q, sync3_q, stab_q, stab_d;

    assign pin_raw = {prog_serial_clock, prog_serial_data_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_comb
            begin
                stab_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : stab_q[gi];
            end
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    stab_q[gi]  <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    stab_q[gi]  <= stab_d[gi];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Serial shifter: receive on rising clock, send on falling clock
    logic       sck_rise, sck_fall;
    logic [7:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d, rx_byte_d;
    logic [2:0] bit_q, bit_d;
    logic       tx_act_q, tx_act_d, rx_vld_d, sd_o_d;

    assign sck_rise = stab_d[1] && !stab_q[1];
    assign sck_fall = !stab_d[1] && stab_q[1];

    always_comb
    begin
        rx_sh_d   = rx_sh_q;
        tx_sh_d   = tx_sh_q;
        bit_d     = bit_q;
        tx_act_d  = tx_act_q;
        rx_byte_d = icp_rx_byte_q;
        rx_vld_d  = 1'b0;
        sd_o_d    = prog_serial_data_o_q;
        if (icp_tx_load && !tx_act_q)
        begin
            // Msb goes out at load so the first rising clock already sees it
            sd_o_d   = icp_tx_byte[7];
            tx_sh_d  = {icp_tx_byte[6:0], 1'b0};
            tx_act_d = 1'b1;
            bit_d    = 3'h0;
        end
        else if (tx_act_q && sck_fall)
        begin
            sd_o_d  = tx_sh_q[7];
            tx_sh_d = {tx_sh_q[6:0], 1'b0};
        end
        else if (tx_act_q && sck_rise)
        begin
            bit_d = bit_q + 3'h1;
            if (bit_q == PTD_ICP_LAST_BIT)
                tx_act_d = 1'b0;
        end
        else if (sck_rise)
        begin
            rx_sh_d = {rx_sh_q[6:0], stab_q[0]};
            bit_d   = bit_q + 3'h1;
            if (bit_q == PTD_ICP_LAST_BIT)
            begin
                rx_byte_d = {rx_sh_q[6:0], stab_q[0]};
                rx_vld_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_sh_q               <= 8'h00;
            tx_sh_q               <= 8'h00;
            bit_q                 <= 3'h0;
            tx_act_q              <= 1'b0;
            icp_rx_byte_q         <= 8'h00;
            icp_rx_valid_q        <= 1'b0;
            prog_serial_data_o_q  <= 1'b0;
            prog_serial_data_oe_q <= 1'b0;
        end
        else
        begin
            rx_sh_q               <= rx_sh_d;
            tx_sh_q               <= tx_sh_d;
            bit_q                 <= bit_d;
            tx_act_q              <= tx_act_d;
            icp_rx_byte_q         <= rx_byte_d;
            icp_rx_valid_q        <= rx_vld_d;
            prog_serial_data_o_q  <= sd_o_d;
            prog_serial_data_oe_q <= tx_act_d;
        end
    end

    // ==================================================================
    // Assertions
    property p_reset_vec;
        @(posedge clk_sys) rst |=> (pc_q == PTD_PC_RESET_VEC);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

    property p_tbl_addr;
        @(posedge clk_sys) disable iff (rst)
        (tbl_st_q == TBL_IDLE && tbl_req.valid && !tbl_req.last_page)
        |=> (pm_addr_q == {$past(tbhp_q[2:0]), $past(tblp_q)}) && pm_rd_q;
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");

    property p_tbl_last;
        @(posedge clk_sys) disable iff (rst)
        (tbl_st_q == TBL_IDLE && tbl_req.valid && tbl_req.last_page)
        |=> (pm_addr_q[10:8] == PTD_LAST_PAGE) && (pm_addr_q[7:0] == $past(tblp_q));
    endproperty
    a_tbl_last: assert property (p_tbl_last) else $error("last page address wrong");

    property p_tbl_two;
        @(posedge clk_sys) disable iff (rst)
        (tbl_st_q == TBL_IDLE && tbl_req.valid)
        |=> tbl_busy_q [*2] ##1 (!tbl_busy_q && tbl_done_q);
    endproperty
    a_tbl_two: assert property (p_tbl_two) else $error("table read not two cycles");

    property p_table_high_latch_load;
        @(posedge clk_sys) disable iff (rst)
        tbl_wr |=> (table_high_latch_q == $past(pm_word_ext[15:8]));
    endproperty
    a_table_high_latch_load: assert property (p_table_high_latch_load) else $error("high latch not loaded");

    property p_table_high_latch_ro;
        @(posedge clk_sys) disable iff (rst)
        !tbl_wr |=> $stable(table_high_latch_q);
    endproperty
    a_table_high_latch_ro: assert property (p_table_high_latch_ro) else $error("high latch changed by software");

    property p_eec_bank0;
        @(posedge clk_sys) disable iff (rst)
        (acc_take && dm_req.addr == PTD_EEC_ADDR && !acc_bank1) |=> !eeprom_sel_q && !sfr_rd_q;
    endproperty
    a_eec_bank0: assert property (p_eec_bank0) else $error("eeprom reg decoded in bank 0");

    property p_direct_bank0;
        @(posedge clk_sys) disable iff (rst)
        (acc_take && dm_req.wr && !dm_req.indirect && dm_req.addr == PTD_GP_BASE)
        |-> gp_we;
    endproperty
    a_direct_bank0: assert property (p_direct_bank0) else $error("direct access left bank 0");

    property p_unimpl_zero;
        @(posedge clk_sys) disable iff (rst)
        (acc_take && dm_req.rd && acc_rg == RG_NONE) ##1 1'b1 |=> (dm_rdata_q == PTD_UNIMPL);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not 00");

    property p_bank_bit;
        @(posedge clk_sys) disable iff (rst)
        bank_select_pointer_q[7:1] == 7'h00;
    endproperty
    a_bank_bit: assert property (p_bank_bit) else $error("bank pointer upper bits set");

    c_tbl_read:  cover property (@(posedge clk_sys) disable iff (rst) tbl_done_q);
    c_bank1_eec: cover property (@(posedge clk_sys) disable iff (rst) eeprom_sel_q && sfr_rd_q);
    c_gp_read:   cover property (@(posedge clk_sys) disable iff (rst)
                                 dm_rvalid_q && rd_rg_q == RG_GPRAM);
    c_icp_byte:  cover property (@(posedge clk_sys) disable iff (rst) icp_rx_valid_q);

endmodule : ptd_core

// *** test/tb.sv ***
// Self-checking bench for the program table read path and data map
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", n, e, g); errors++; end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ptd_pkg::*;
    // ==================================================================
    // Design inputs and outputs
    logic clk_sys = 1'b0, rst = 1'b1, pc_step = 1'b0, pc_load = 1'b0;
    logic [10:0] pc_load_addr = 11'h000, pc_q, pm_addr_q;
    ptd_tbl_req_t tbl_req = '0;
    ptd_dm_req_t  dm_req = '0;
    logic [15:0] pm_data = 16'h0000;
    logic [7:0] sfr_rdata = 8'h00, bsp, dm_rdata_q, rx_byte, q;
    logic sfr_hit = 1'b0, sclk = 1'b0, sdat = 1'b0, busy, done, pm_rd, rvalid, ee_sel, rx_valid;
    logic tx_load = 1'b0, sd_o, sd_oe, sfr_r, sfr_w;
    logic [7:0] tx_byte = 8'h00, sfr_a, sfr_wd, rx_got = 8'hxx;
    int errors = 0, compares = 0, ee_cnt = 0, rx_cnt = 0;
    always #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (ee_sel === 1'b1) ee_cnt++;
    // The receive pulse comes while the clock pin is still high, so catch it here
    always @(negedge clk_sys)
    begin
        if (rx_valid === 1'b1)
        begin
            rx_got = rx_byte;
            rx_cnt++;
        end
    end
    ptd_core ptd_core_i (.clk_sys(clk_sys), .rst(rst), .pc_step(pc_step), .pc_load(pc_load),
        .pc_load_addr(pc_load_addr), .pc_q(pc_q), .tbl_req(tbl_req), .tbl_busy_q(busy),
        .tbl_done_q(done), .pm_addr_q(pm_addr_q), .pm_rd_q(pm_rd), .pm_data(pm_data),
        .dm_req(dm_req), .dm_rdata_q(dm_rdata_q), .dm_rvalid_q(rvalid),
        .bank_select_pointer_q(bsp), .sfr_addr_q(sfr_a), .sfr_wdata_q(sfr_wd), .sfr_rd_q(sfr_r),
        .sfr_wr_q(sfr_w), .eeprom_sel_q(ee_sel), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .prog_serial_clock(sclk), .prog_serial_data_i(sdat), .prog_serial_data_o_q(sd_o),
        .prog_serial_data_oe_q(sd_oe), .icp_rx_byte_q(rx_byte), .icp_rx_valid_q(rx_valid),
        .icp_tx_load(tx_load), .icp_tx_byte(tx_byte));
    // ==================================================================
    // Shared tasks
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task dm(input logic r, w, ind, input logic [7:0] a, d);
        @(posedge clk_sys) dm_req <= '{r, w, ind, a, d};
        @(posedge clk_sys) dm_req <= '0;
        q = 8'hxx;
        // Answer lands two edges after the take; bounded wait
        if (r) repeat (4) @(negedge clk_sys) if (rvalid === 1'b1) q = dm_rdata_q;
    endtask : dm
    task tbl(input logic lp, input logic [7:0] dst, input logic [15:0] w, input logic [10:0] a);
        @(posedge clk_sys) begin tbl_req <= '{1'b1, lp, dst}; pm_data <= w; end
        @(posedge clk_sys) tbl_req <= '0;
        @(negedge clk_sys);
        `CHK("pm_addr", a, pm_addr_q)
        `CHK("busy1", 2'b11, {busy, pm_rd})
        @(negedge clk_sys) `CHK("busy2", 3'b100, {busy, pm_rd, done})
        @(negedge clk_sys) `CHK("done", 2'b01, {busy, done})
        @(posedge clk_sys) pm_data <= ~w;
        dm(1, 0, 0, dst, 0); `CHK("dest", w[7:0], q)
        dm(1, 0, 0, PTD_TABLE_HIGH_LATCH_ADDR, 0); `CHK("latch", w[15:8], q)
    endtask : tbl
    task finish_test;
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // ==================================================================
    // Scenarios
    task t_pc;
        @(posedge clk_sys) begin pc_load <= 1'b1; pc_load_addr <= 11'h7FE; pc_step <= 1'b1; end
        @(posedge clk_sys) pc_load <= 1'b0;
        cyc(1); pc_step <= 1'b0;
        @(negedge clk_sys) `CHK("pc_step", 11'h7FF, pc_q)
        @(posedge clk_sys) rst <= 1'b1;
        cyc(3); rst <= 1'b0;
        @(negedge clk_sys) `CHK("pc_rst", 11'h000, pc_q)
    endtask : t_pc
    task t_table;
        dm(0, 1, 0, PTD_TBLP_ADDR, 8'h06); dm(0, 1, 0, PTD_TBHP_ADDR, 8'h07);
        tbl(0, 8'h80, 16'h5A1A, 11'h706);
        dm(0, 1, 0, PTD_TABLE_HIGH_LATCH_ADDR, 8'hFF);
        dm(1, 0, 0, PTD_TABLE_HIGH_LATCH_ADDR, 0); `CHK("latch_ro", 8'h5A, q)
        dm(0, 1, 0, PTD_TBHP_ADDR, 8'h02); dm(0, 1, 0, PTD_TBLP_ADDR, 8'h05);
        dm(1, 0, 0, PTD_TBLP_ADDR, 0); `CHK("tblp", 8'h05, q)
        tbl(0, 8'h81, 16'h00C3, 11'h205);
        tbl(1, 8'h82, 16'h3C0F, 11'h705);
    endtask : t_table
    task t_map;
        dm(0, 1, 0, 8'h80, 8'h11); dm(0, 1, 0, 8'hBF, 8'h22);
        dm(1, 0, 0, 8'h80, 0); `CHK("gp80", 8'h11, q)
        dm(1, 0, 0, 8'hBF, 0); `CHK("gpBF", 8'h22, q)
        dm(0, 1, 0, 8'hC0, 8'h33); dm(1, 0, 0, 8'hC0, 0); `CHK("unimpl", 8'h00, q)
        dm(1, 0, 0, 8'h10, 0); `CHK("sfr_miss", 8'h00, q)
        sfr_hit <= 1'b1; sfr_rdata <= 8'hA5;
        dm(1, 0, 1, 8'h10, 0); `CHK("sfr_b0", 8'hA5, q)
        dm(0, 1, 0, 8'h10, 8'h3C);
        @(negedge clk_sys) `CHK("sfr_wr", {2'b10, 8'h10, 8'h3C}, {sfr_w, sfr_r, sfr_a, sfr_wd})
        dm(0, 1, 0, 8'h40, 8'h01); cyc(1); `CHK("ee_b0", 0, ee_cnt)
        dm(0, 1, 0, PTD_BSP_ADDR, 8'hFF);
        @(negedge clk_sys) `CHK("bsp", 8'h01, bsp)
        dm(1, 0, 1, 8'h10, 0); `CHK("sfr_b1", 8'hA5, q)
        dm(1, 0, 0, 8'h80, 0); `CHK("direct", 8'h11, q)
        dm(1, 0, 1, 8'h80, 0); `CHK("bank1", 8'h00, q)
        dm(0, 1, 1, 8'h40, 8'h01); cyc(1); `CHK("ee_b1", 1, ee_cnt)
    endtask : t_map
    task t_icp;
        int i;
        for (i = 7; i >= 0; i--)
        begin
            @(posedge clk_sys) sdat <= i[0];
            cyc(5); sclk <= 1'b1; cyc(5); sclk <= 1'b0;
        end
        cyc(6);
        `CHK("icp_rx", 8'hAA, rx_got)
        `CHK("icp_rx_cnt", 1, rx_cnt)
    endtask : t_icp
    task t_icp_tx;
        int i;
        logic [7:0] got;
        @(posedge clk_sys) begin tx_load <= 1'b1; tx_byte <= 8'hC5; end
        @(posedge clk_sys) tx_load <= 1'b0;
        @(negedge clk_sys) `CHK("icp_oe1", 1'b1, sd_oe)
        for (i = 7; i >= 0; i--)
        begin
            @(negedge clk_sys) got[i] = sd_o;
            @(posedge clk_sys) sclk <= 1'b1;
            cyc(5); sclk <= 1'b0; cyc(5);
        end
        @(negedge clk_sys) `CHK("icp_tx", 8'hC5, got)
        `CHK("icp_oe0", 1'b0, sd_oe)
    endtask : t_icp_tx
    // ==================================================================
    // Main sequence and watchdog
    initial
    begin
        cyc(5); rst <= 1'b0;
        @(negedge clk_sys) `CHK("rst", 19'h00000, {pc_q, bsp})
        t_pc; t_table; t_map; t_icp; t_icp_tx;
        finish_test;
    end
    initial
    begin
        #500000;
        errors++;
        finish_test;
    end
endmodule : tb
